// >>> fam_cmd_decode.sv
// Serial NOR command front end: address width, segments, quad mode, read decode.
// Assumes a host in serial mode 0 or 3, an array port on the serial clock,
// and a core clock for erase requests and mode status.
//
// Function
// - Enter-wide command sets flag, 32-bit addresses
// - Enter/exit wide commands switch address mode
// - Dedicated 4-byte opcodes take 32-bit address
// - Wide mode ignores segment bits
// - Segment register supplies address bits 26..24
// - Upper five bits read zero, resets zero
// - Eight 128Mb segments chosen by low bits
// - Continuous read crosses segments, register unchanged
// - Read start lies in selected segment
// - Chip erase ignores segment
// - Program and erase stay inside segment
// - Quad enable opcode enters quad command mode
// - Quad reset opcode returns to single-line
// - Mode commands need byte-boundary chip select rise
// - Sample on rising, shift out on falling
`timescale 1ns/10ps
`include "fam_map.svh"
module fam_cmd_decode import fam_pkg::*; (
  // Core clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] serial_io_lines_i,
  output logic [3:0] serial_io_lines_o,
  output logic [3:0] serial_io_lines_oe_n_o,
  // Array port on the serial clock
  output logic [`FAM_ARRAY_AW-1:0] mem_addr_o,
  input wire logic [7:0] mem_rdata_i,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  // Core side
  output logic erase_req_o,
  output fam_erase_t erase_o,
  output fam_mode_t mode_o
);

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  function automatic fam_dec_t decode(input logic [7:0] c, input logic q, input logic w);
    fam_dec_t d;
    d = '{valid: 1'b1, op: OP_READ, four: w, addr_lanes: q ? 3'd4 : 3'd1,
          data_lanes: q ? 3'd4 : 3'd1, dummy: 1'b1};
    unique case (c)
      `FAM_OP_READ, `FAM_OP_READ4: d.dummy = 1'b0;
      `FAM_OP_FAST, `FAM_OP_FAST4, `FAM_OP_FAST_DTR, `FAM_OP_FAST_DTR4: ;
      `FAM_OP_DUAL_IO, `FAM_OP_DUAL_IO4, `FAM_OP_DUAL_DTR: begin
        d.addr_lanes = 3'd2;
        d.data_lanes = 3'd2;
      end
      `FAM_OP_DUAL_OUT, `FAM_OP_DUAL_OUT4: d.data_lanes = 3'd2;
      `FAM_OP_QUAD_IO, `FAM_OP_QUAD_IO4: begin
        d.addr_lanes = 3'd4;
        d.data_lanes = 3'd4;
      end
      `FAM_OP_QUAD_OUT, `FAM_OP_QUAD_OUT4: d.data_lanes = 3'd4;
      `FAM_OP_PROG, `FAM_OP_PROG4: d.op = OP_PROG;
      `FAM_OP_SE, `FAM_OP_SE4: d.op = OP_SE;
      `FAM_OP_BE32: d.op = OP_BE32;
      `FAM_OP_BE64: d.op = OP_BE64;
      `FAM_OP_CE_A, `FAM_OP_CE_B: d.op = OP_CE;
      `FAM_OP_WIDE_ON: d.op = OP_WIDE_ON;
      `FAM_OP_WIDE_OFF: d.op = OP_WIDE_OFF;
      `FAM_OP_QUAD_ON: d.op = OP_QUAD_ON;
      `FAM_OP_QUAD_OFF: d.op = OP_QUAD_OFF;
      `FAM_OP_SEG_WR: d.op = OP_SEG_WR;
      `FAM_OP_SEG_RD: d.op = OP_SEG_RD;
      default: d.valid = 1'b0;
    endcase
    // Dedicated 4-byte opcodes always carry 32 address bits
    if (c inside {`FAM_OP_READ4, `FAM_OP_FAST4, `FAM_OP_DUAL_IO4, `FAM_OP_DUAL_OUT4,
        `FAM_OP_QUAD_IO4, `FAM_OP_QUAD_OUT4, `FAM_OP_FAST_DTR4, `FAM_OP_PROG4,
        `FAM_OP_SE4}) begin
      d.four = 1'b1;
    end
    // In quad command mode only the quad I/O read is a legal read
    if (q && d.op == OP_READ && !(c inside {`FAM_OP_QUAD_IO, `FAM_OP_QUAD_IO4})) begin
      d.valid = 1'b0;
    end
    if (d.op != OP_READ) begin
      d.dummy = 1'b0;
    end
    return d;
  endfunction

  // ---------------------------------------------------------------
  // Link-side state
  // ---------------------------------------------------------------
  logic wide_addr_flag;
  logic quad_command_mode;
  logic [`FAM_SEG_W-1:0] segment_extension;
  logic frame_tog;
  logic seen_tog;
  fam_state_t st;
  fam_dec_t dec;
  logic [31:0] sh;
  logic [5:0] cnt;
  logic [2:0] bmod;
  logic [`FAM_ARRAY_AW-1:0] start_addr;
  logic [`FAM_ARRAY_AW-1:0] prog_ptr;
  logic [`FAM_ARRAY_AW-1:0] rd_ptr;
  logic [`FAM_SEG_W-1:0] seg_new;
  logic ofirst;
  logic [2:0] ocnt;
  logic [7:0] obuf;
  logic ev_tog;
  fam_erase_t ev_rec;
  fam_mode_t ev_mode;

  // Current-frame view: a new frame starts from the command phase
  logic fresh;
  fam_state_t cur_st;
  logic [5:0] cur_cnt;
  logic [2:0] lanes;
  logic [31:0] sh_n;
  logic [5:0] cnt_n;
  logic [5:0] addr_bits;
  fam_dec_t dec_n;
  assign fresh = seen_tog != frame_tog;
  assign cur_st = fresh ? S_CMD : st;
  assign cur_cnt = fresh ? 6'h00 : cnt;
  assign addr_bits = dec.four ? `FAM_ADDR4_BITS : `FAM_ADDR3_BITS;
  assign dec_n = decode(sh_n[7:0], quad_command_mode, wide_addr_flag);

  // Lane count of the phase in progress
  always_comb begin
    unique case (cur_st)
      S_CMD: lanes = quad_command_mode ? 3'd4 : 3'd1;
      S_ADDR: lanes = dec.addr_lanes;
      default: lanes = dec.data_lanes;
    endcase
    unique case (lanes)
      3'd4: sh_n = {sh[27:0], serial_io_lines_i};
      3'd2: sh_n = {sh[29:0], serial_io_lines_i[1:0]};
      default: sh_n = {sh[30:0], serial_io_lines_i[0]};
    endcase
    cnt_n = cur_cnt + {3'b000, lanes};
  end

  // ---------------------------------------------------------------
  // Input phases, sampled on the rising serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= S_CMD;
      dec <= '0;
      sh <= '0;
      cnt <= '0;
      bmod <= '0;
      start_addr <= '0;
      prog_ptr <= '0;
      seg_new <= '0;
      seen_tog <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= '0;
    end else begin
      seen_tog <= frame_tog;
      sh <= sh_n;
      cnt <= cnt_n;
      bmod <= (fresh ? 3'h0 : bmod) + lanes;
      mem_wr_o <= 1'b0;
      // A new frame leaves the old phase behind
      if (fresh) begin
        st <= S_CMD;
      end
      unique case (cur_st)
        S_CMD: if (cnt_n == `FAM_BYTE_BITS) begin
          dec <= dec_n;
          cnt <= '0;
          st <= S_DONE;
          if (dec_n.valid) begin
            unique case (dec_n.op)
              OP_READ, OP_PROG, OP_SE, OP_BE32, OP_BE64: st <= S_ADDR;
              OP_SEG_WR: st <= S_DIN;
              OP_SEG_RD: st <= S_DOUT;
              default: st <= S_DONE;
            endcase
          end
        end
        S_ADDR: if (cnt_n == addr_bits) begin
          cnt <= '0;
          // Wide address ignores the segment, else segment forms the top bits
          if (dec.four) begin
            start_addr <= sh_n[`FAM_ARRAY_AW-1:0];
            prog_ptr <= sh_n[`FAM_ARRAY_AW-1:0];
          end else begin
            start_addr <= {segment_extension, sh_n[23:0]};
            prog_ptr <= {segment_extension, sh_n[23:0]};
          end
          unique case (dec.op)
            OP_READ: st <= dec.dummy ? S_DUMMY : S_DOUT;
            OP_PROG: st <= S_DIN;
            default: st <= S_DONE;
          endcase
        end
        S_DUMMY: if (cnt + 6'h01 == `FAM_DUMMY_CLKS) begin
          cnt <= '0;
          st <= S_DOUT;
        end else begin
          cnt <= cnt + 6'h01;
        end
        S_DIN: begin
          // Step past the byte just written; page wrap keeps it in page and segment
          if (mem_wr_o) begin
            prog_ptr[`FAM_PAGE_BITS-1:0] <= prog_ptr[`FAM_PAGE_BITS-1:0] + 8'h01;
          end
          if (cnt_n == `FAM_BYTE_BITS) begin
            cnt <= '0;
            if (dec.op == OP_SEG_WR) begin
              seg_new <= sh_n[`FAM_SEG_W-1:0];
              st <= S_DONE;
            end else begin
              mem_wr_o <= 1'b1;
              mem_wdata_o <= sh_n[7:0];
            end
          end
        end
        S_DOUT, S_DONE: cnt <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output phase, shifted on the falling serial clock
  // ---------------------------------------------------------------
  logic [7:0] out_src;
  logic [2:0] olanes;
  assign out_src = (dec.op == OP_SEG_RD) ? {5'b00000, segment_extension} : mem_rdata_i;
  assign olanes = (dec.op == OP_SEG_RD) ? (quad_command_mode ? 3'd4 : 3'd1) : dec.data_lanes;

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ofirst <= 1'b1;
      ocnt <= '0;
      obuf <= '0;
      rd_ptr <= '0;
    end else if (st != S_DOUT || fresh) begin
      ofirst <= 1'b1;
      ocnt <= '0;
    end else if (ocnt == 3'h0) begin
      obuf <= out_src;
      ocnt <= 3'(4'd8 - {1'b0, olanes});
      ofirst <= 1'b0;
      // Running address wraps over the whole array, not the segment
      if (dec.op == OP_READ) begin
        rd_ptr <= (ofirst ? start_addr : rd_ptr) + 27'h000_0001;
      end
    end else begin
      obuf <= obuf << olanes;
      ocnt <= ocnt - olanes;
    end
  end

  // Current output bits per lane width
  logic [7:0] obyte;
  assign obyte = (ocnt == 3'h0) ? out_src : (obuf << olanes);
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_io_lines_o <= '0;
    end else if (olanes == 3'd4) begin
      serial_io_lines_o <= obyte[7:4];
    end else if (olanes == 3'd2) begin
      serial_io_lines_o <= {2'b00, obyte[7:6]};
    end else begin
      serial_io_lines_o <= {2'b00, obyte[7], 1'b0};
    end
  end

  // Drive only while selected and in the output phase
  assign serial_io_lines_oe_n_o = (cs_n_i || fresh || st != S_DOUT) ? 4'hF :
    (olanes == 3'd4) ? 4'h0 : (olanes == 3'd2) ? 4'hC : 4'hD;
  assign mem_addr_o = (st == S_DIN) ? prog_ptr : (ofirst ? start_addr : rd_ptr);

  // ---------------------------------------------------------------
  // Commands that act at the end of the frame
  // ---------------------------------------------------------------
  always_ff @(posedge cs_n_i or posedge rst_i) begin
    if (rst_i) begin
      wide_addr_flag <= 1'b0;
      quad_command_mode <= 1'b0;
      segment_extension <= `FAM_SEG_RESET;
      frame_tog <= 1'b0;
      ev_tog <= 1'b0;
      ev_rec <= '0;
    end else begin
      frame_tog <= ~frame_tog;
      // Executed only when select rose on a byte boundary
      if (!fresh && st == S_DONE && bmod == 3'h0) begin
        unique case (dec.op)
          OP_WIDE_ON: wide_addr_flag <= 1'b1;
          OP_WIDE_OFF: wide_addr_flag <= 1'b0;
          OP_QUAD_ON: quad_command_mode <= 1'b1;
          OP_QUAD_OFF: quad_command_mode <= 1'b0;
          OP_SEG_WR: segment_extension <= seg_new;
          default: ;
        endcase
        ev_rec <= '{op: dec.op, addr: (dec.op == OP_CE) ? '0 : start_addr};
        ev_tog <= ~ev_tog;
      end
    end
  end
  assign ev_mode = '{wide_addr_flag: wide_addr_flag, quad_command_mode: quad_command_mode,
    segment_extension: segment_extension};

  // ---------------------------------------------------------------
  // Crossing to the core clock
  // ---------------------------------------------------------------
  logic ev_s1;
  logic ev_s2;
  logic ev_s3;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
      erase_req_o <= 1'b0;
      erase_o <= '0;
      mode_o <= '0;
    end else begin
      ev_s1 <= ev_tog;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      erase_req_o <= 1'b0;
      // Record is stable: it changes only one frame later
      if (ev_s2 != ev_s3) begin
        mode_o <= ev_mode;
        if (ev_rec.op inside {OP_SE, OP_BE32, OP_BE64, OP_CE}) begin
          erase_req_o <= 1'b1;
          erase_o <= ev_rec;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_wide_addr_len: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (!fresh && st == S_ADDR && wide_addr_flag) |-> addr_bits == 6'h20)
    else $error("wide mode address not 32 bits");
  chk_four_opcode: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (cur_st == S_CMD && !quad_command_mode && cnt_n == 6'h08 && sh_n[7:0] == 8'h13) |=>
    (dec.four && st == S_ADDR))
    else $error("4-byte read opcode not taken as 32-bit");
  chk_seg_ignored: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (st == S_ADDR && dec.four && cnt_n == addr_bits) |=> start_addr == $past(sh_n[26:0]))
    else $error("segment used with 4-byte address");
  chk_seg_compose: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (st == S_ADDR && !dec.four && cnt_n == addr_bits) |=>
    start_addr[26:24] == segment_extension && start_addr[23:0] == $past(sh_n[23:0]))
    else $error("3-byte address not joined with segment");
  chk_quad_reject: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (cur_st == S_CMD && quad_command_mode && cnt_n == 6'h08 && sh_n[7:0] == 8'h0B)
    |=> st == S_DONE [*2])
    else $error("single-line read accepted in quad mode");
  chk_quad_lanes: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (cur_st == S_CMD && quad_command_mode) |-> lanes == 3'd4)
    else $error("quad command phase not on four lanes");
  chk_read_cross: assert property (@(negedge sclk_i) disable iff (rst_i || cs_n_i)
    (!fresh && st == S_DOUT && dec.op == OP_READ && ocnt == 3'h0 &&
    mem_addr_o[23:0] == 24'hFF_FFFF) |=> rd_ptr[23:0] == 24'h00_0000 &&
    rd_ptr[26:24] == $past(mem_addr_o[26:24]) + 3'h1 && $stable(segment_extension))
    else $error("continuous read did not cross into next segment");
  chk_page_stay: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
    (st == S_DIN && dec.op == OP_PROG) |=> prog_ptr[26:8] == $past(prog_ptr[26:8]))
    else $error("program left its page");
  chk_seg_readback: assert property (@(negedge sclk_i) disable iff (rst_i || cs_n_i)
    (st == S_DOUT && dec.op == OP_SEG_RD) |-> out_src[7:3] == 5'b00000)
    else $error("segment upper bits not zero");
  chk_event_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
    erase_req_o |=> !erase_req_o)
    else $error("erase request longer than one cycle");
endmodule

// >>> fam_host_model.sv
// Host model of the serial link: mode 0, one, two or four lanes.
// Assumes the bench calls its tasks and feeds back the device pin outputs.
`timescale 1ns/10ps
module fam_host_model (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  // Device pin outputs
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_n_i
);
  // ---------------------------------------------------------------
  // Pin drive and frame tasks
  // ---------------------------------------------------------------
  logic [3:0] drv;
  logic drv_en;

  // Idle: clock low and still, deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    drv = 4'h0;
    drv_en = 1'b0;
  end

  // Undriven lines show the inverse of the last host value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_o[i] = !dev_oe_n_i[i] ? dev_io_i[i] : (drv_en ? drv[i] : ~drv[i]);
    end
  end

  // One clock: data held over the rising edge
  task automatic tick();
    #40 sclk_o = 1'b1;
    #40 sclk_o = 1'b0;
  endtask

  // Shift a value out MSB first; full address width as given
  task automatic put(input logic [31:0] v, input int nbits, input int lanes);
    logic [31:0] t;
    drv_en = 1'b1;
    for (int i = nbits - lanes; i >= 0; i -= lanes) begin
      t = v >> i;
      drv = (lanes == 4) ? t[3:0] : (lanes == 2) ? {2'b00, t[1:0]} : {3'b000, t[0]};
      tick();
    end
  endtask

  // Dummy clocks with the lines released
  task automatic idle(input int n);
    drv_en = 1'b0;
    repeat (n) tick();
  endtask

  // Take one byte, sampled just before each rising edge
  task automatic get(output logic [7:0] b, input int lanes);
    drv_en = 1'b0;
    b = 8'h00;
    for (int k = 0; k < 8; k += lanes) begin
      #40;
      b = (lanes == 4) ? {b[3:0], io_o} : (lanes == 2) ? {b[5:0], io_o[1:0]} : {b[6:0], io_o[1]};
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
  endtask

  // Select the device
  task automatic start();
    cs_n_o = 1'b0;
    #40;
  endtask

  // Deselect wherever the frame stands and keep the deselect time
  task automatic stop(input int gap);
    drv_en = 1'b0;
    cs_n_o = 1'b1;
    #gap;
  endtask
endmodule

// >>> fam_map.svh
// Constants of the flash address-mode and quad command front end.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FAM_MAP_SVH
`define FAM_MAP_SVH

// -----------------------------------------------------------------
// First-byte opcodes
// -----------------------------------------------------------------
`define FAM_OP_READ      8'h03
`define FAM_OP_FAST      8'h0B
`define FAM_OP_DUAL_IO   8'hBB
`define FAM_OP_DUAL_OUT  8'h3B
`define FAM_OP_QUAD_IO   8'hEB
`define FAM_OP_QUAD_OUT  8'h6B
`define FAM_OP_FAST_DTR  8'h0D
`define FAM_OP_DUAL_DTR  8'hBD
`define FAM_OP_READ4     8'h13
`define FAM_OP_FAST4     8'h0C
`define FAM_OP_DUAL_IO4  8'hBC
`define FAM_OP_DUAL_OUT4 8'h3C
`define FAM_OP_QUAD_IO4  8'hEC
`define FAM_OP_QUAD_OUT4 8'h6C
`define FAM_OP_FAST_DTR4 8'h0E
`define FAM_OP_PROG      8'h02
`define FAM_OP_PROG4     8'h12
`define FAM_OP_SE        8'h20
`define FAM_OP_SE4       8'h21
`define FAM_OP_BE32      8'h52
`define FAM_OP_BE64      8'hD8
`define FAM_OP_CE_A      8'h60
`define FAM_OP_CE_B      8'hC7
`define FAM_OP_QUAD_ON   8'h35
`define FAM_OP_QUAD_OFF  8'hF5
`define FAM_OP_WIDE_ON   8'hB7
`define FAM_OP_WIDE_OFF  8'hE9
`define FAM_OP_SEG_WR    8'hC5
`define FAM_OP_SEG_RD    8'hC8

// -----------------------------------------------------------------
// Widths, fields, resets, counts
// -----------------------------------------------------------------
`define FAM_ARRAY_AW     27
`define FAM_SEG_W        3
`define FAM_SEG_RESET    3'h0
`define FAM_PAGE_BITS    8
`define FAM_DUMMY_CLKS   6'h08
`define FAM_ADDR3_BITS   6'h18
`define FAM_ADDR4_BITS   6'h20
`define FAM_BYTE_BITS    6'h08
`endif

// >>> fam_pkg.sv
// Types of the flash address-mode and quad command front end.
// Assumes fam_map.svh is on the include path.
`include "fam_map.svh"
package fam_pkg;
  // Decoded command kinds
  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_PROG, OP_SE, OP_BE32, OP_BE64, OP_CE,
    OP_WIDE_ON, OP_WIDE_OFF, OP_QUAD_ON, OP_QUAD_OFF, OP_SEG_WR, OP_SEG_RD
  } fam_op_t;

  // Frame phases, Gray coded along the usual path
  typedef enum logic [2:0] {
    S_CMD = 3'b000, S_ADDR = 3'b001, S_DUMMY = 3'b011,
    S_DOUT = 3'b010, S_DIN = 3'b110, S_DONE = 3'b111
  } fam_state_t;

  // Result of opcode decode
  typedef struct packed {
    logic valid;
    fam_op_t op;
    logic four;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic dummy;
  } fam_dec_t;

  // Erase request handed to the core clock
  typedef struct packed {
    fam_op_t op;
    logic [`FAM_ARRAY_AW-1:0] addr;
  } fam_erase_t;

  // Mode state reported to the core clock
  typedef struct packed {
    logic wide_addr_flag;
    logic quad_command_mode;
    logic [`FAM_SEG_W-1:0] segment_extension;
  } fam_mode_t;
endpackage

// >>> test_fam_cmd_decode.sv
// Bench of the flash command front end: frames through the host model.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/10ps
`include "fam_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_fam_cmd_decode import fam_pkg::*;;
  // ---------------------------------------------------------------
  // Design, host and array
  // ---------------------------------------------------------------
  logic clock_i, rst_i, sclk, cs_n, mem_wr, erase_req;
  logic [3:0] io_in, io_out, oe_n;
  logic [26:0] mem_addr, wr_addr;
  logic [7:0] mem_rdata, mem_wdata, wr_data, b;
  fam_erase_t erase, last_er;
  fam_mode_t mode;
  int fails, tests_run, n_er, c1;
  logic [7:0] ops [8] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD};
  int al [8] = '{1, 1, 2, 1, 4, 1, 1, 2};
  int ol [8] = '{1, 1, 2, 2, 4, 4, 1, 2};

  // Array content marks the segment in each byte
  function automatic logic [7:0] dat(input logic [26:0] a);
    return a[7:0] ^ {5'h00, a[26:24]};
  endfunction
  assign mem_rdata = dat(mem_addr);

  fam_cmd_decode fam_cmd_decode_inst (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .serial_io_lines_i(io_in), .serial_io_lines_o(io_out),
    .serial_io_lines_oe_n_o(oe_n), .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata),
    .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .erase_req_o(erase_req), .erase_o(erase),
    .mode_o(mode));
  fam_host_model fam_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io_in),
    .dev_io_i(io_out), .dev_oe_n_i(oe_n));

  // Core clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // Erase requests and array writes
  always @(posedge clock_i) begin
    if (erase_req === 1'b1) begin
      n_er++;
      last_er = erase;
    end
  end
  always @(negedge sclk) begin
    if (mem_wr === 1'b1) begin
      wr_addr = mem_addr;
      wr_data = mem_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Frame tasks and scenarios
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Command byte with an optional data byte
  task automatic cmd(input logic [7:0] op, input int ln, input int nd = 0,
      input logic [7:0] d = 8'h00);
    fam_host_model_inst.start();
    fam_host_model_inst.put({24'h0, op}, 8, ln);
    if (nd > 0) fam_host_model_inst.put({24'h0, d}, 8, ln);
    fam_host_model_inst.stop(400);
  endtask

  // Read frame, one or two bytes compared
  task automatic rd(input logic [7:0] op, input int cl, input logic [31:0] a, input int ab,
      input int aln, input int dm, input int oln, input int n, input logic [7:0] e0,
      input logic [7:0] e1);
    fam_host_model_inst.start();
    fam_host_model_inst.put({24'h0, op}, 8, cl);
    fam_host_model_inst.put(a, ab, aln);
    fam_host_model_inst.idle(dm);
    fam_host_model_inst.get(b, oln);
    `CHK(b, e0)
    if (n > 1) begin
      fam_host_model_inst.get(b, oln);
      `CHK(b, e1)
    end
    fam_host_model_inst.stop(400);
  endtask

  // Raw frame of up to three fields and idle clocks; nothing may be driven
  task automatic frm(input logic [31:0] v0, input int n0, input logic [31:0] v1, input int n1,
      input logic [31:0] v2, input int n2, input int ln, input int dm, input int gap);
    fam_host_model_inst.start();
    fam_host_model_inst.put(v0, n0, ln);
    fam_host_model_inst.put(v1, n1, ln);
    fam_host_model_inst.put(v2, n2, ln);
    fam_host_model_inst.idle(dm);
    `CHK(oe_n, 4'hF)
    fam_host_model_inst.stop(gap);
  endtask

  // Erase frame, one request expected within a bounded wait
  task automatic er(input logic [7:0] op, input logic [31:0] a, input int ab,
      input fam_op_t eo, input logic [26:0] ea);
    int c0;
    c0 = n_er;
    fam_host_model_inst.start();
    fam_host_model_inst.put({24'h0, op}, 8, 1);
    fam_host_model_inst.put(a, ab, 1);
    fam_host_model_inst.stop(400);
    for (int k = 0; k < 8 && n_er == c0; k++) @(posedge clock_i);
    `CHK(n_er - c0, 1)
    `CHK(last_er, {eo, ea})
  endtask

  // Hang guard
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end

  initial begin
    rst_i = 1'b1;
    fails = 0;
    tests_run = 0;
    n_er = 0;
    repeat (5) @(posedge clock_i);
    #2 rst_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #13;
    `CHK(mode, 5'h00)
    rd(`FAM_OP_SEG_RD, 1, 0, 0, 1, 0, 1, 1, 8'h00, 8'h00);
    cmd(`FAM_OP_SEG_WR, 1, 1, 8'hFD);
    `CHK(mode.segment_extension, 3'h5)
    rd(`FAM_OP_SEG_RD, 1, 0, 0, 1, 0, 1, 1, 8'h05, 8'h00);
    rd(`FAM_OP_READ, 1, 24'hFF_FFFF, 24, 1, 0, 1, 2, 8'hFA, 8'h06);
    `CHK(mode.segment_extension, 3'h5)
    for (int i = 0; i < 8; i++) begin
      rd(ops[i], 1, 24'h00_1230 + i, 24, al[i], (i == 0) ? 0 : 8, ol[i], 2,
        dat(27'({3'h5, 24'h00_1230} + i)), dat(27'({3'h5, 24'h00_1231} + i)));
    end
    er(`FAM_OP_SE, 24'hFF_F000, 24, OP_SE, {3'h5, 24'hFF_F000});
    er(`FAM_OP_BE64, 24'h01_0000, 24, OP_BE64, {3'h5, 24'h01_0000});
    er(`FAM_OP_CE_B, 0, 0, OP_CE, 27'h0);
    er(`FAM_OP_CE_A, 0, 0, OP_CE, 27'h0);
    c1 = n_er;
    frm(32'h0000_00C7, 8, 32'h0000_0000, 4, 32'h0000_0000, 0, 1, 0, 800);
    `CHK(n_er, c1)
    frm(32'h0000_0002, 8, 32'h00FF_FFFF, 24, 32'h0000_A53C, 16, 1, 0, 400);
    `CHK(wr_addr, {3'h5, 24'hFF_FF00})
    `CHK(wr_data, 8'h3C)
    cmd(`FAM_OP_WIDE_ON, 1);
    `CHK(mode.wide_addr_flag, 1'b1)
    rd(`FAM_OP_READ, 1, 32'h0212_3456, 32, 1, 0, 1, 1, 8'h54, 8'h00);
    er(`FAM_OP_SE, 32'h0300_0000, 32, OP_SE, 27'h300_0000);
    cmd(`FAM_OP_WIDE_OFF, 1);
    `CHK(mode.wide_addr_flag, 1'b0)
    rd(`FAM_OP_READ, 1, 24'h00_0010, 24, 1, 0, 1, 1, 8'h15, 8'h00);
    rd(`FAM_OP_READ4, 1, 32'h0123_4567, 32, 1, 0, 1, 1, 8'h66, 8'h00);
    rd(`FAM_OP_QUAD_IO4, 1, 32'h0765_4321, 32, 4, 8, 4, 1, 8'h26, 8'h00);
    cmd(`FAM_OP_QUAD_ON, 1);
    `CHK(mode.quad_command_mode, 1'b1)
    frm(32'h0B00_0000, 32, 32'h0000_0000, 0, 32'h0000_0000, 0, 4, 8, 400);
    rd(`FAM_OP_QUAD_IO, 4, 24'h00_0040, 24, 4, 8, 4, 2, 8'h45, 8'h44);
    rd(`FAM_OP_SEG_RD, 4, 0, 0, 4, 0, 4, 1, 8'h05, 8'h00);
    cmd(`FAM_OP_QUAD_OFF, 4);
    `CHK(mode.quad_command_mode, 1'b0)
    rd(`FAM_OP_READ, 1, 24'h00_0020, 24, 1, 0, 1, 1, 8'h25, 8'h00);
    wrap_up();
  end
endmodule
